// [include/ufb_defines.vh]
// Constants for the fractional baud generator and transmit path
`ifndef UFB_DEFINES_VH
`define UFB_DEFINES_VH

// ----------------------------------------
// Register select codes
// ----------------------------------------
`define UFB_SEL_DIV_LOW      3'h0
`define UFB_SEL_DIV_HIGH     3'h1
`define UFB_SEL_DIV_FRAC     3'h2
`define UFB_SEL_TX_HOLD      3'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UFB_RST_DIV_LOW      8'h01
`define UFB_RST_DIV_HIGH     8'h00
`define UFB_RST_DIV_FRAC     8'h00

// ----------------------------------------
// Fraction register fields
// ----------------------------------------
`define UFB_FRAC_MSB         3
`define UFB_FRAC_LSB         0
`define UFB_MODE_MSB         5
`define UFB_MODE_LSB         4
`define UFB_MODE_16X         2'h0
`define UFB_MODE_8X          2'h1
`define UFB_MODE_4X          2'h2

// ----------------------------------------
// Sampling periods per bit, minus one
// ----------------------------------------
`define UFB_BIT_LAST_16X     4'hf
`define UFB_BIT_LAST_8X      4'h7
`define UFB_BIT_LAST_4X      4'h3

// ----------------------------------------
// Prescaler, FIFO and word length
// ----------------------------------------
`define UFB_PRESC_LAST       2'h3
`define UFB_FIFO_DEPTH       64
`define UFB_FIFO_AW          6
`define UFB_FIFO_FULL        7'h40
`define UFB_HOLD_FULL        7'h01
`define UFB_LEN_5BIT         2'h0
`define UFB_LEN_6BIT         2'h1
`define UFB_LEN_7BIT         2'h2
`define UFB_LEN_8BIT         2'h3

`endif

// [core/ufb_tx_baud.v]
// One channel: fractional baud rate generator and transmitter
`timescale 1ns/1ps
`default_nettype none
`include "ufb_defines.vh"

module ufb_tx_baud (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       reg_wr,
    input  wire [2:0] reg_sel,
    input  wire [7:0] reg_wdata,
    input  wire       prescale_div4,
    input  wire       fifo_enable,
    input  wire [1:0] word_len,
    input  wire       parity_en,
    input  wire       parity_even,
    input  wire       stop_two,
    input  wire       tx_empty_int_en,
    output reg  [7:0] divisor_low_byte,
    output reg  [7:0] divisor_high_byte,
    output reg  [7:0] divisor_fraction_and_sampling,
    output reg        sample_tick,
    output reg        tx_serial,
    output reg        holding_empty,
    output reg        shifter_empty,
    output reg        tx_empty_irq,
    output wire       tx_fifo_full
);

    // ----------------------------------------
    // Transmit states
    // ----------------------------------------
    localparam [4:0] ST_IDLE   = 5'h01;
    localparam [4:0] ST_START  = 5'h02;
    localparam [4:0] ST_DATA   = 5'h04;
    localparam [4:0] ST_PARITY = 5'h08;
    localparam [4:0] ST_STOP   = 5'h10;

    reg  [1:0]  presc_r;
    reg  [16:0] baud_cnt_r;
    reg  [3:0]  frac_acc_r;
    reg  [7:0]  fifo_mem [0:`UFB_FIFO_DEPTH-1];
    reg  [`UFB_FIFO_AW-1:0] wr_ptr_r;
    reg  [`UFB_FIFO_AW-1:0] rd_ptr_r;
    reg  [6:0]  fifo_cnt_r;
    reg  [4:0]  state_r;
    reg  [4:0]  state_nxt;
    reg  [7:0]  shift_r;
    reg  [3:0]  tick_cnt_r;
    reg  [2:0]  bit_cnt_r;
    reg         parity_r;
    reg         stop_cnt_r;

    wire        presc_tick;
    wire [4:0]  frac_sum;
    wire [16:0] period_last;
    wire [1:0]  mode;
    reg  [3:0]  bit_last;
    reg  [2:0]  data_last;
    wire        bit_done;
    wire        wr_hold;
    wire        push;
    wire        pop;
    wire [6:0]  fifo_limit;

    // ----------------------------------------
    // Divisor registers
    // ----------------------------------------
    // Reset divisor is one; software must reprogram it for a real rate
    always @(posedge clk) begin
        if (!rst_b) begin
            divisor_low_byte              <= `UFB_RST_DIV_LOW;
            divisor_high_byte             <= `UFB_RST_DIV_HIGH;
            divisor_fraction_and_sampling <= `UFB_RST_DIV_FRAC;
        end else if (reg_wr) begin
            case (reg_sel)
                `UFB_SEL_DIV_LOW:  divisor_low_byte <= reg_wdata;
                `UFB_SEL_DIV_HIGH: divisor_high_byte <= reg_wdata;
                `UFB_SEL_DIV_FRAC: divisor_fraction_and_sampling <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    // Divide by four gives a one-cycle enable every fourth clock
    assign presc_tick = prescale_div4 ? (presc_r == `UFB_PRESC_LAST) : 1'b1;

    always @(posedge clk) begin
        if (!rst_b)
            presc_r <= 2'h0;
        else
            presc_r <= presc_r + 2'h1;
    end

    // ----------------------------------------
    // Fractional baud rate generator
    // ----------------------------------------
    // Each sampling period adds the fraction to an accumulator; a carry stretches
    // that period by one prescaled clock, so sixteen periods gain exactly the
    // fraction in cycles, spread rather than bunched
    assign frac_sum = {1'b0, frac_acc_r} +
                      {1'b0, divisor_fraction_and_sampling[`UFB_FRAC_MSB:`UFB_FRAC_LSB]};
    // A zero integer part is taken as the 65536 end of the range; the subtraction
    // stays 16 bits wide so zero wraps to 65535 instead of a 17-bit underflow
    assign period_last = {1'b0, ({divisor_high_byte, divisor_low_byte} - 16'h1)}
                         + {16'h0, frac_sum[4]};

    always @(posedge clk) begin
        if (!rst_b) begin
            baud_cnt_r  <= 17'h0;
            frac_acc_r  <= 4'h0;
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            if (presc_tick) begin
                if (baud_cnt_r >= period_last) begin
                    baud_cnt_r  <= 17'h0;
                    frac_acc_r  <= frac_sum[3:0];
                    sample_tick <= 1'b1;
                end else begin
                    baud_cnt_r <= baud_cnt_r + 17'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // Bit length from the sampling mode, data length from the word length
    // ----------------------------------------
    // The reserved mode code falls back to 16X; odd fractions in 8X show
    // the allowed 1/16 bit-time jitter since carries land unevenly per bit
    assign mode = divisor_fraction_and_sampling[`UFB_MODE_MSB:`UFB_MODE_LSB];

    always @* begin
        case (mode)
            `UFB_MODE_8X: bit_last = `UFB_BIT_LAST_8X;
            `UFB_MODE_4X: bit_last = `UFB_BIT_LAST_4X;
            default:      bit_last = `UFB_BIT_LAST_16X;
        endcase
        case (word_len)
            `UFB_LEN_5BIT: data_last = 3'h4;
            `UFB_LEN_6BIT: data_last = 3'h5;
            `UFB_LEN_7BIT: data_last = 3'h6;
            default:       data_last = 3'h7;
        endcase
    end

    assign bit_done = sample_tick && (tick_cnt_r == bit_last);

    // ----------------------------------------
    // Transmit FIFO
    // ----------------------------------------
    // With the FIFO off the same storage acts as a single holding register
    assign fifo_limit   = fifo_enable ? `UFB_FIFO_FULL : `UFB_HOLD_FULL;
    assign tx_fifo_full = (fifo_cnt_r >= fifo_limit);
    assign wr_hold      = reg_wr && (reg_sel == `UFB_SEL_TX_HOLD);
    // Writes into a full FIFO are dropped; the host is expected to poll status
    assign push         = wr_hold && !tx_fifo_full;
    assign pop          = (state_r == ST_IDLE) && sample_tick && (fifo_cnt_r != 7'h0);

    always @(posedge clk) begin
        if (push)
            fifo_mem[wr_ptr_r] <= reg_wdata;
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_r   <= {`UFB_FIFO_AW{1'b0}};
            rd_ptr_r   <= {`UFB_FIFO_AW{1'b0}};
            fifo_cnt_r <= 7'h0;
        end else begin
            if (push)
                wr_ptr_r <= wr_ptr_r + {{(`UFB_FIFO_AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_r <= rd_ptr_r + {{(`UFB_FIFO_AW-1){1'b0}}, 1'b1};
            case ({push, pop})
                2'b10:   fifo_cnt_r <= fifo_cnt_r + 7'h1;
                2'b01:   fifo_cnt_r <= fifo_cnt_r - 7'h1;
                default: fifo_cnt_r <= fifo_cnt_r;
            endcase
        end
    end

    // ----------------------------------------
    // Transmit state machine
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (pop)
                    state_nxt = ST_START;
            ST_START:
                if (bit_done)
                    state_nxt = ST_DATA;
            ST_DATA:
                if (bit_done && (bit_cnt_r == data_last))
                    state_nxt = parity_en ? ST_PARITY : ST_STOP;
            ST_PARITY:
                if (bit_done)
                    state_nxt = ST_STOP;
            ST_STOP:
                if (bit_done && (stop_cnt_r || !stop_two))
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // Shifter, bit counters and the serial line
    always @(posedge clk) begin
        if (!rst_b) begin
            state_r    <= ST_IDLE;
            shift_r    <= 8'h0;
            tick_cnt_r <= 4'h0;
            bit_cnt_r  <= 3'h0;
            parity_r   <= 1'b0;
            stop_cnt_r <= 1'b0;
            tx_serial  <= 1'b1;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE)
                tick_cnt_r <= 4'h0;
            else if (sample_tick)
                tick_cnt_r <= bit_done ? 4'h0 : tick_cnt_r + 4'h1;
            case (state_r)
                ST_IDLE: begin
                    tx_serial <= 1'b1;
                    if (pop) begin
                        shift_r    <= fifo_mem[rd_ptr_r];
                        parity_r   <= ~parity_even;
                        bit_cnt_r  <= 3'h0;
                        stop_cnt_r <= 1'b0;
                        tx_serial  <= 1'b0;
                    end
                end
                ST_START: begin
                    if (bit_done)
                        tx_serial <= shift_r[0];
                end
                ST_DATA: begin
                    if (bit_done) begin
                        parity_r  <= parity_r ^ shift_r[0];
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        shift_r   <= {1'b0, shift_r[7:1]};
                        if (bit_cnt_r == data_last)
                            tx_serial <= parity_en ? (parity_r ^ shift_r[0]) : 1'b1;
                        else
                            tx_serial <= shift_r[1];
                    end
                end
                ST_PARITY: begin
                    if (bit_done)
                        tx_serial <= 1'b1;
                end
                ST_STOP: begin
                    if (bit_done)
                        stop_cnt_r <= 1'b1;
                end
                default: tx_serial <= 1'b1;
            endcase
        end
    end

    // ----------------------------------------
    // Line status and transmit empty interrupt
    // ----------------------------------------
    // Holding-empty follows the store count, so in either mode it rises as the
    // last byte moves into the shifter; shifter-empty also waits for the stop bit
    always @(posedge clk) begin
        if (!rst_b) begin
            holding_empty <= 1'b1;
            shifter_empty <= 1'b1;
            tx_empty_irq  <= 1'b0;
        end else begin
            holding_empty <= (fifo_cnt_r == 7'h0);
            shifter_empty <= (fifo_cnt_r == 7'h0) && (state_r == ST_IDLE);
            tx_empty_irq  <= (fifo_cnt_r == 7'h0) && tx_empty_int_en;
        end
    end

endmodule // ufb_tx_baud
`default_nettype wire

// [test/ufb_tx_baud_sva.sv]
// Port assertions for the baud generator and transmitter
`timescale 1ns/1ps
`default_nettype none
module ufb_tx_baud_sva (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       reg_wr,
    input wire logic [2:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    input wire logic       prescale_div4,
    input wire logic       tx_empty_int_en,
    input wire logic [7:0] divisor_low_byte,
    input wire logic [7:0] divisor_high_byte,
    input wire logic [7:0] divisor_fraction_and_sampling,
    input wire logic       sample_tick,
    input wire logic       tx_serial,
    input wire logic       holding_empty,
    input wire logic       shifter_empty,
    input wire logic       tx_empty_irq,
    input wire logic       tx_fifo_full
);
    // --------
    // Relations
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Unit divisor without prescale: the generator must tick on every clock
    wire div_one = divisor_low_byte == 8'h01 && divisor_high_byte == 8'h00
        && divisor_fraction_and_sampling[3:0] == 4'h0 && !prescale_div4;
    chk_reset_vals: assert property (disable iff (1'b0) !rst_b |=>
        {divisor_low_byte, divisor_high_byte, divisor_fraction_and_sampling} == 24'h010000)
        else $error("divisor reset value wrong");
    chk_low_write: assert property (reg_wr && reg_sel == 3'h0 |=>
        divisor_low_byte == $past(reg_wdata)) else $error("low byte write lost");
    chk_frac_write: assert property (reg_wr && reg_sel == 3'h2 |=>
        divisor_fraction_and_sampling == $past(reg_wdata)) else $error("fraction write lost");
    chk_tick_unit: assert property (sample_tick && div_one && $past(div_one) && !reg_wr
        |=> sample_tick) else $error("unit divisor missed a tick");
    chk_pre_gap: assert property (sample_tick && prescale_div4 |=> !sample_tick [*3])
        else $error("prescaled ticks too close");
    chk_edge_tick: assert property ($changed(tx_serial) |->
        sample_tick || $past(sample_tick)) else $error("line changed off a tick");
    chk_idle_high: assert property (shifter_empty |-> tx_serial)
        else $error("line low while shifter empty");
    chk_irq_level: assert property ($past(rst_b) |->
        tx_empty_irq == (holding_empty && $past(tx_empty_int_en)))
        else $error("irq level wrong");
    chk_hold_busy: assert property (reg_wr && reg_sel == 3'h3 && !tx_fifo_full
        |-> ##2 !holding_empty) else $error("write left holding empty");
endmodule // ufb_tx_baud_sva
bind ufb_tx_baud ufb_tx_baud_sva u_sva (
    .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .prescale_div4(prescale_div4), .tx_empty_int_en(tx_empty_int_en),
    .divisor_low_byte(divisor_low_byte), .divisor_high_byte(divisor_high_byte),
    .divisor_fraction_and_sampling(divisor_fraction_and_sampling),
    .sample_tick(sample_tick), .tx_serial(tx_serial), .holding_empty(holding_empty),
    .shifter_empty(shifter_empty), .tx_empty_irq(tx_empty_irq), .tx_fifo_full(tx_fifo_full));
`default_nettype wire

// [test/ufb_rx_model.sv]
// Remote serial receiver model that deframes the transmit line
`timescale 1ns/1ps
`default_nettype none
module ufb_rx_model (
    input  wire logic       clk,
    input  wire logic       tx_serial,
    input  wire logic       listen,
    input  wire logic [7:0] bit_clks,
    input  wire logic [3:0] nbits,
    input  wire logic       par_en,
    input  wire logic       par_even,
    output var  logic       rx_done,
    output var  logic [7:0] rx_byte,
    output var  logic       rx_err
);
    logic [7:0] b;
    logic       e;
    // Sample mid-bit and resync on every start edge, so fraction jitter never piles up
    initial begin
        rx_done = 1'b0;
        rx_byte = 8'h00;
        rx_err = 1'b0;
        forever begin
            @(negedge tx_serial iff listen);
            b = 8'h00;
            repeat (bit_clks / 2) @(posedge clk);
            e = tx_serial;
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_clks) @(posedge clk);
                b[i] = tx_serial;
            end
            if (par_en) begin
                repeat (bit_clks) @(posedge clk);
                e = e | (tx_serial !== (^b ^ !par_even));
            end
            repeat (bit_clks) @(posedge clk);
            e = e | !tx_serial;
            rx_byte = b;
            rx_err = e;
            rx_done = 1'b1;
            @(posedge clk);
            rx_done = 1'b0;
        end
    end
endmodule // ufb_rx_model
`default_nettype wire

// [test/test_ufb_tx_baud.sv]
// Self-checking testbench for the baud generator and transmitter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
$display("Error %0t: got %0h want %0h", $time, (a), (b)); end end
module test_ufb_tx_baud;
    logic       clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, pre = 1'b0, fifo_en = 1'b0;
    logic       par_en = 1'b0, par_even = 1'b0, stop_two = 1'b0, int_en = 1'b0, listen = 1'b1;
    logic [2:0] reg_sel = 3'h0;
    logic [7:0] reg_wdata = 8'h00, bclk = 8'h10, lo, hi, fr, rxb;
    logic [1:0] wl = 2'h3;
    logic       tick, txd, hold_e, shift_e, irq, full, rx_done, rx_err;
    int         failures = 0, cmp_count = 0, n;
    logic [8:0] exp_q[$];
    logic [8:0] exp_v;
    ufb_tx_baud u_dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .prescale_div4(pre), .fifo_enable(fifo_en), .word_len(wl),
        .parity_en(par_en), .parity_even(par_even), .stop_two(stop_two),
        .tx_empty_int_en(int_en), .divisor_low_byte(lo), .divisor_high_byte(hi),
        .divisor_fraction_and_sampling(fr), .sample_tick(tick), .tx_serial(txd),
        .holding_empty(hold_e), .shifter_empty(shift_e), .tx_empty_irq(irq), .tx_fifo_full(full));
    ufb_rx_model u_rx (.clk(clk), .tx_serial(txd), .listen(listen), .bit_clks(bclk),
        .nbits(4'h5 + {2'h0, wl}), .par_en(par_en), .par_even(par_even), .rx_done(rx_done),
        .rx_byte(rxb), .rx_err(rx_err));
    // --------
    // Clock, tasks, checking
    // --------
    initial forever #50 clk = ~clk;
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(negedge clk);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // Prescale only changes under reset, so the divider phase never straddles it
    task automatic rst(input logic p);
        @(negedge clk);
        rst_b = 1'b0;
        pre = p;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        `CHK({hold_e, shift_e, txd, full, irq}, 5'h1c)
        `CHK({lo, hi, fr}, 24'h010000)
    endtask
    // Wait for room first: the empty flag lags the store by one cycle
    task automatic send(input logic [7:0] d);
        @(negedge clk);
        n = 0;
        while ((fifo_en ? full : !hold_e) !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        `CHK(n < 2000, 1'b1)
        exp_q.push_back({1'b0, d & (8'hff >> (2'h3 - wl))});
        wr(3'h3, d);
    endtask
    task automatic meas(input int want, input int tol);
        int t;
        t = 0;
        n = 0;
        while (tick !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (t < 64 && n < 9000) begin
            @(negedge clk);
            n++;
            t += (tick === 1'b1);
        end
        `CHK(n >= want - tol && n <= want + tol, 1'b1)
    endtask
    task automatic run(input logic [7:0] dv, input logic [3:0] f, input logic [1:0] md,
                       input logic p, input logic [1:0] w, input logic pe, input logic fe);
        rst(p);
        fifo_en = fe;
        wl = w;
        par_en = pe;
        par_even = 1'($urandom);
        stop_two = 1'($urandom);
        int_en = 1'($urandom);
        // The spare mode code runs as 16X
        bclk = 8'(((dv * 16 + f) * ((md == 2'h3) ? 16 : (16 >> md)) * (p ? 4 : 1)) / 16);
        wr(3'h0, dv);
        wr(3'h1, 8'h00);
        wr(3'h2, {2'h0, md, f});
        `CHK({lo, hi, fr}, {dv, 8'h00, 2'h0, md, f})
        meas((dv * 16 + f) * 4 * (p ? 4 : 1), p ? 8 : 2);
        repeat (3) send(8'($urandom));
        n = 0;
        while ((shift_e !== 1'b1 || exp_q.size() != 0) && n < 30000) begin
            @(negedge clk);
            n++;
        end
        `CHK(n < 30000, 1'b1)
        `CHK({hold_e, txd, irq}, {2'h3, int_en})
    endtask
    // Each received character retires the oldest note
    always @(posedge rx_done) begin
        if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
        else begin
            // Pop once: the compare macro reads its arguments twice
            exp_v = exp_q.pop_front();
            `CHK({rx_err, rxb}, exp_v)
        end
    end
    task automatic test_done();
        $display("Checks %0d, errors %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Five runs need roughly 6,000 clocks; the limit of 40,000 clocks allows over six times that
    initial begin
        #4_000_000;
        failures++;
        test_done();
    end
    initial begin
        void'($urandom(92062));
        run(8'd1, 4'h0, 2'h0, 1'b0, 2'h3, 1'b0, 1'b1);
        run(8'd2, 4'h8, 2'h1, 1'b0, 2'h0, 1'b1, 1'b0);
        run(8'd1, 4'h4, 2'h2, 1'b1, 2'h1, 1'b1, 1'b1);
        run(8'd3, 4'h2, 2'h0, 1'b0, 2'h2, 1'b0, 1'b0);
        run(8'd2, 4'h0, 2'h3, 1'b0, 2'h3, 1'b1, 1'b1);
        // Slow divisor keeps the store filling until it refuses, then reset aborts it
        rst(1'b0);
        fifo_en = 1'b1;
        listen = 1'b0;
        wr(3'h1, 8'h10);
        n = 0;
        while (full !== 1'b1 && n < 80) begin
            wr(3'h3, 8'(n));
            n++;
        end
        `CHK(n == 64 || n == 65, 1'b1)
        rst(1'b0);
        listen = 1'b1;
        test_done();
    end
endmodule // test_ufb_tx_baud
`default_nettype wire
